//--- shared/arc_pkg.sv
`default_nettype none
package arc_pkg;
   // register port geometry
   localparam int ARC_ADDR_W = 3;
   localparam int ARC_DATA_W = 8;
   localparam int ARC_RES_W = 10;

   // register indices on the plain port
   localparam logic [2:0] ARC_OFF_SC1 = 3'h0;
   localparam logic [2:0] ARC_OFF_SC2 = 3'h1;
   localparam logic [2:0] ARC_OFF_RES_HI = 3'h2;
   localparam logic [2:0] ARC_OFF_RES_LO = 3'h3;
   localparam logic [2:0] ARC_OFF_CV_HI = 3'h4;
   localparam logic [2:0] ARC_OFF_CV_LO = 3'h5;
   localparam logic [2:0] ARC_OFF_CFG = 3'h6;

   // status_control_one fields
   localparam int ARC_SC1_CONVERSION_COMPLETE_FLAG_BIT = 7;
   localparam int ARC_SC1_CH_MSB = 4;
   localparam int ARC_SC1_CH_LSB = 0;
   localparam logic [4:0] ARC_CH_DISABLED = 5'h1f;

   // status_control_two fields
   localparam int ARC_SC2_ACTIVE_BIT = 7;
   localparam int ARC_SC2_TRIG_BIT = 6;
   localparam int ARC_SC2_CMPEN_BIT = 5;
   localparam int ARC_SC2_CMPGE_BIT = 4;

   // configuration: conversion-width field
   localparam int ARC_CFG_MODE_MSB = 3;
   localparam int ARC_CFG_MODE_LSB = 2;
   localparam logic [1:0] ARC_MODE_8BIT = 2'h0;
   localparam logic [1:0] ARC_MODE_10BIT = 2'h2;

   // values after reset
   localparam logic [7:0] ARC_RST_BYTE = 8'h00;
   localparam logic [4:0] ARC_RST_CHANNEL = 5'h1f;
   localparam logic [1:0] ARC_RST_MODE = 2'h0;

   // conversion sequencing
   typedef enum logic {ARC_IDLE, ARC_BUSY} arc_conv_state_t;

   // the active width follows the mode field
   function automatic logic arc_is_10bit(input logic [1:0] mode);
      return mode == ARC_MODE_10BIT;
   endfunction
endpackage
`default_nettype wire

//--- src/arc_trig_sync.sv
`timescale 1ns/1ps
`default_nettype none
module arc_trig_sync (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // trigger level in, start pulse out
   input wire logic i_level,
   output logic o_rise
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } arc_sync_state_t;

   arc_sync_state_t r;
   arc_sync_state_t next_r;

   // first stage feeds only the second one
   always_comb begin
      next_r.meta = i_level;
      next_r.sync = r.meta;
      next_r.last = r.sync;
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // one request per rising transition
   assign o_rise = r.sync & ~r.last;
endmodule
`default_nettype wire

//--- src/arc_cmp.sv
`timescale 1ns/1ps
`default_nettype none
module arc_cmp #(
   parameter int RES_W = 10
) (
   // result and compare value
   input wire logic [RES_W-1:0] i_result,
   input wire logic [RES_W-1:0] i_value,
   // configuration
   input wire logic i_width10,
   input wire logic i_greater_equal,
   // condition
   output logic o_true
);
   logic [RES_W-1:0] res_eff;
   logic [RES_W-1:0] val_eff;

   // 8-bit mode drops the upper bits of both sides
   always_comb begin
      res_eff = i_result;
      val_eff = i_value;
      if (!i_width10) begin
         res_eff[RES_W-1:8] = '0;
         val_eff[RES_W-1:8] = '0;
      end
   end

   // unsigned compare, direction from the ge bit
   assign o_true = i_greater_equal ? (res_eff >= val_eff)
                                   : (res_eff < val_eff);
endmodule
`default_nettype wire

//--- src/arc_ctrl.sv
// What this block does
// - active flag sets when conversion starts, clears on finish or abort.
// - trigger select 0 starts on control-one write; 1 on hardware trigger.
// - automatic compare works only while compare enable is set.
// - direction 1: condition true when result is at least the compare value.
// - direction 0, default: condition true only when result is below it.
// - high result holds top two bits; both zero in 8-bit mode.
// - results load at every completion unless locked or compare enabled and false.
// - 10-bit mode: high result read locks transfers until low result read.
// - results completing while locked are discarded, never buffered.
// - 8-bit mode: no lock between the two result bytes.
// - changing the width mode invalidates both result registers.
// - low result holds low eight bits of 10-bit or all of 8-bit.
// - high compare bits used only in 10-bit mode with compare on.
// - low compare byte compared against low result bits in both modes.
// - complete flag sets at every completion, or only on true compare.
// - complete flag clears on control-one write or low result read.
// - control-one write aborts; restarts with trigger select 0 unless channel is all ones.
// - width code 00 selects 8-bit, 10 selects 10-bit, others reserved.
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl #(
   parameter int RES_W = 10
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // register port
   input wire logic [arc_pkg::ARC_ADDR_W-1:0] i_addr,
   input wire logic [arc_pkg::ARC_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [arc_pkg::ARC_DATA_W-1:0] o_rdata,
   // hardware trigger from another block
   input wire logic i_hw_trigger_input,
   // analog core handshake
   output logic o_conv_start,
   output logic o_conv_abort,
   output logic [4:0] o_channel_select,
   output logic [1:0] o_mode,
   input wire logic i_conv_done,
   input wire logic [RES_W-1:0] i_conv_result,
   // status levels
   output logic o_conversion_active_flag,
   output logic o_conversion_complete_flag
);
   import arc_pkg::*;

   typedef struct packed {
      arc_conv_state_t state;
      logic active;
      logic conversion_complete_flag;
      logic trigger_select;
      logic compare_enable;
      logic compare_greater_equal;
      logic [4:0] channel_select;
      logic [1:0] mode;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic [7:0] cv_hi;
      logic [7:0] cv_lo;
      logic lock;
      logic start;
      logic abort;
      logic [7:0] rdata;
   } arc_ctrl_state_t;

   arc_ctrl_state_t r;
   arc_ctrl_state_t next_r;

   logic hw_rise;
   logic cmp_true;
   logic [RES_W-1:0] cmp_value;

   // helpers for the decode below
   logic wr_sc1;
   logic wr_sc2;
   logic wr_cvh;
   logic wr_cvl;
   logic wr_cfg;
   logic rd_hi;
   logic rd_lo;
   logic width10;
   logic done_ok;
   logic load_ok;
   logic sw_start;
   logic hw_start;
   logic [1:0] new_mode;

   // hardware trigger crossing and edge pick
   arc_trig_sync u_trig (
      .i_clock(i_clock),
      .i_srst(i_srst),
      .i_level(i_hw_trigger_input),
      .o_rise(hw_rise)
   );

   // compare value spans both compare bytes
   assign cmp_value = {r.cv_hi[RES_W-9:0], r.cv_lo};

   // compare of the incoming result against the stored value
   arc_cmp #(
      .RES_W(RES_W)
   ) u_cmp (
      .i_result(i_conv_result),
      .i_value(cmp_value),
      .i_width10(width10),
      .i_greater_equal(r.compare_greater_equal),
      .o_true(cmp_true)
   );

   // address decode for writes and side-effect reads
   always_comb begin
      wr_sc1 = 1'b0;
      wr_sc2 = 1'b0;
      wr_cvh = 1'b0;
      wr_cvl = 1'b0;
      wr_cfg = 1'b0;
      rd_hi = 1'b0;
      rd_lo = 1'b0;
      if (i_addr == ARC_OFF_SC1) begin
         wr_sc1 = i_wr;
      end else if (i_addr == ARC_OFF_SC2) begin
         wr_sc2 = i_wr;
      end else if (i_addr == ARC_OFF_RES_HI) begin
         rd_hi = i_rd;
      end else if (i_addr == ARC_OFF_RES_LO) begin
         rd_lo = i_rd;
      end else if (i_addr == ARC_OFF_CV_HI) begin
         wr_cvh = i_wr;
      end else if (i_addr == ARC_OFF_CV_LO) begin
         wr_cvl = i_wr;
      end else if (i_addr == ARC_OFF_CFG) begin
         wr_cfg = i_wr;
      end
   end

   // conditions shared by the next-state logic
   always_comb begin
      width10 = arc_is_10bit(r.mode);
      new_mode = i_wdata[ARC_CFG_MODE_MSB:ARC_CFG_MODE_LSB];
      // an abort in the same cycle wins over a finishing conversion
      done_ok = i_conv_done && (r.state == ARC_BUSY) && !wr_sc1;
      // a failed compare only blocks the load while compare is on
      load_ok = !(r.compare_enable && !cmp_true) && !r.lock;
      sw_start = wr_sc1 && !r.trigger_select
                 && (i_wdata[ARC_SC1_CH_MSB:ARC_SC1_CH_LSB] != ARC_CH_DISABLED);
      // a trigger seen during a conversion is dropped, not queued
      hw_start = hw_rise && r.trigger_select && (r.state == ARC_IDLE)
                 && (r.channel_select != ARC_CH_DISABLED);
   end

   // read data mux, answered in the following cycle
   function automatic logic [7:0] read_mux(input logic [2:0] addr, input arc_ctrl_state_t s);
      logic [7:0] d;
      d = 8'h00;
      if (addr == ARC_OFF_SC1) begin
         d[ARC_SC1_CONVERSION_COMPLETE_FLAG_BIT] = s.conversion_complete_flag;
         d[ARC_SC1_CH_MSB:ARC_SC1_CH_LSB] = s.channel_select;
      end else if (addr == ARC_OFF_SC2) begin
         d[ARC_SC2_ACTIVE_BIT] = s.active;
         d[ARC_SC2_TRIG_BIT] = s.trigger_select;
         d[ARC_SC2_CMPEN_BIT] = s.compare_enable;
         d[ARC_SC2_CMPGE_BIT] = s.compare_greater_equal;
      end else if (addr == ARC_OFF_RES_HI) begin
         d = s.res_hi;
      end else if (addr == ARC_OFF_RES_LO) begin
         d = s.res_lo;
      end else if (addr == ARC_OFF_CV_HI) begin
         d = s.cv_hi;
      end else if (addr == ARC_OFF_CV_LO) begin
         d = s.cv_lo;
      end else if (addr == ARC_OFF_CFG) begin
         d[ARC_CFG_MODE_MSB:ARC_CFG_MODE_LSB] = s.mode;
      end
      return d;
   endfunction

   // next state: bus effects first, then completion, then starts
   always_comb begin
      next_r = r;
      next_r.start = 1'b0;
      next_r.abort = 1'b0;
      next_r.rdata = 8'h00;

      // read data stand for exactly one cycle
      if (i_rd) begin
         next_r.rdata = read_mux(i_addr, r);
      end

      // control one: channel, clears the complete flag, aborts
      if (wr_sc1) begin
         next_r.channel_select = i_wdata[ARC_SC1_CH_MSB:ARC_SC1_CH_LSB];
         next_r.conversion_complete_flag = 1'b0;
         if (r.state == ARC_BUSY) begin
            next_r.abort = 1'b1;
            next_r.state = ARC_IDLE;
            next_r.active = 1'b0;
         end
      end

      // control two: bits 7 and 3..0 are not stored, low two are reserved
      if (wr_sc2) begin
         next_r.trigger_select = i_wdata[ARC_SC2_TRIG_BIT];
         next_r.compare_enable = i_wdata[ARC_SC2_CMPEN_BIT];
         next_r.compare_greater_equal = i_wdata[ARC_SC2_CMPGE_BIT];
      end

      // compare value bytes; only the low two bits of the high byte exist
      if (wr_cvh) begin
         next_r.cv_hi = {6'h00, i_wdata[1:0]};
      end
      if (wr_cvl) begin
         next_r.cv_lo = i_wdata;
      end

      // width mode: any change throws the held result away
      if (wr_cfg) begin
         next_r.mode = new_mode;
         if (new_mode != r.mode) begin
            next_r.res_hi = 8'h00;
            next_r.res_lo = 8'h00;
            next_r.lock = 1'b0;
         end
      end

      // read interlock exists only in 10-bit mode
      if (rd_hi && width10) begin
         next_r.lock = 1'b1;
      end
      if (rd_lo) begin
         next_r.lock = 1'b0;
         next_r.conversion_complete_flag = 1'b0;
      end

      // completion: the set beats a low-result-read clear in the same cycle
      if (done_ok) begin
         next_r.state = ARC_IDLE;
         next_r.active = 1'b0;
         if (load_ok) begin
            next_r.res_lo = i_conv_result[7:0];
            // 8-bit results keep the upper byte at zero
            next_r.res_hi = width10 ? {6'h00, i_conv_result[RES_W-1:8]} : 8'h00;
         end
         if (!r.compare_enable || cmp_true) begin
            next_r.conversion_complete_flag = 1'b1;
         end
      end

      // start a conversion from whichever trigger is selected
      if (sw_start || hw_start) begin
         next_r.state = ARC_BUSY;
         next_r.active = 1'b1;
         next_r.start = 1'b1;
      end
   end

   // one register stage for all control state
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         r.state <= ARC_IDLE;
         r.active <= 1'b0;
         r.conversion_complete_flag <= 1'b0;
         r.trigger_select <= 1'b0;
         r.compare_enable <= 1'b0;
         r.compare_greater_equal <= 1'b0;
         r.channel_select <= ARC_RST_CHANNEL;
         r.mode <= ARC_RST_MODE;
         r.res_hi <= ARC_RST_BYTE;
         r.res_lo <= ARC_RST_BYTE;
         r.cv_hi <= ARC_RST_BYTE;
         r.cv_lo <= ARC_RST_BYTE;
         r.lock <= 1'b0;
         r.start <= 1'b0;
         r.abort <= 1'b0;
         r.rdata <= ARC_RST_BYTE;
      end else begin
         r <= next_r;
      end
   end

   // every output straight from the state register
   assign o_rdata = r.rdata;
   assign o_conv_start = r.start;
   assign o_conv_abort = r.abort;
   assign o_channel_select = r.channel_select;
   assign o_mode = r.mode;
   assign o_conversion_active_flag = r.active;
   assign o_conversion_complete_flag = r.conversion_complete_flag;
endmodule
`default_nettype wire

//--- sim/arc_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module arc_ctrl_checker #(
   parameter int RES_W = 10
) (
   // clock, reset, register port
   input wire logic i_clock,
   input wire logic i_srst,
   input wire logic [arc_pkg::ARC_ADDR_W-1:0] i_addr,
   input wire logic [arc_pkg::ARC_DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [arc_pkg::ARC_DATA_W-1:0] o_rdata,
   // trigger and core side
   input wire logic i_hw_trigger_input,
   input wire logic o_conv_start,
   input wire logic o_conv_abort,
   input wire logic [4:0] o_channel_select,
   input wire logic [1:0] o_mode,
   input wire logic i_conv_done,
   input wire logic [RES_W-1:0] i_conv_result,
   // status levels
   input wire logic o_conversion_active_flag,
   input wire logic o_conversion_complete_flag
);
   import arc_pkg::*;
   logic trig;
   logic cmpen;
   logic sc1w;
   logic act;
   logic cc;
   // short aliases keep the properties readable
   assign sc1w = i_wr && i_addr == ARC_OFF_SC1;
   assign act = o_conversion_active_flag;
   assign cc = o_conversion_complete_flag;
   // control-two bits are not visible at the ports, so shadow them
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         trig <= 1'b0;
         cmpen <= 1'b0;
      end else if (i_wr && i_addr == ARC_OFF_SC2) begin
         trig <= i_wdata[ARC_SC2_TRIG_BIT];
         cmpen <= i_wdata[ARC_SC2_CMPEN_BIT];
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_srst);
   AST_START_ACTIVE: assert property (o_conv_start |-> act)
      else $error("start pulse without active flag");
   AST_DONE_CLEARS: assert property (act && i_conv_done && !sc1w |=> !act)
      else $error("active flag held after completion");
   AST_ABORT_CLEARS: assert property (o_conv_abort && !o_conv_start |-> !act)
      else $error("active flag held after abort");
   AST_SW_START: assert property (sc1w && !trig && i_wdata[4:0] != ARC_CH_DISABLED
      |=> o_conv_start)
      else $error("software start missing");
   AST_HW_NEEDS_SEL: assert property (o_conv_start && !$past(sc1w) |-> $past(trig))
      else $error("hardware start without trigger select");
   AST_LO_READ_CLEARS: assert property (i_rd && i_addr == ARC_OFF_RES_LO && !i_conv_done
      |=> !cc)
      else $error("complete flag held after low read");
   AST_SC1_WRITE_CLEARS: assert property (sc1w |=> !cc)
      else $error("complete flag held after control write");
   AST_CONVERSION_COMPLETE_FLAG_SET: assert property (act && i_conv_done && !cmpen && !sc1w |=> cc)
      else $error("complete flag not set");
   AST_HI_ZERO_8BIT: assert property (i_rd && i_addr == ARC_OFF_RES_HI
      && o_mode != ARC_MODE_10BIT |=> o_rdata == 8'h00)
      else $error("high result nonzero in 8-bit mode");
   AST_SC2_LOW_ZERO: assert property (i_rd && i_addr == ARC_OFF_SC2
      |=> o_rdata[3:0] == 4'h0)
      else $error("reserved control bits read nonzero");
   AST_ABORT_PULSE: assert property (sc1w && act |=> o_conv_abort)
      else $error("control write during conversion gave no abort");
   AST_CH_FOLLOWS: assert property (sc1w |=> o_channel_select == $past(i_wdata[4:0]))
      else $error("channel select not taken from control write");
endmodule
bind arc_ctrl arc_ctrl_checker #(.RES_W(RES_W)) u_chk (.i_clock(i_clock), .i_srst(i_srst),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .i_hw_trigger_input(i_hw_trigger_input), .o_conv_start(o_conv_start),
   .o_conv_abort(o_conv_abort), .o_channel_select(o_channel_select), .o_mode(o_mode),
   .i_conv_done(i_conv_done), .i_conv_result(i_conv_result),
   .o_conversion_active_flag(o_conversion_active_flag),
   .o_conversion_complete_flag(o_conversion_complete_flag));
`default_nettype wire

//--- sim/tb_arc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_arc_ctrl;
   import arc_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic trg = 1'b0;
   logic done = 1'b0;
   logic [9:0] res = 10'h000;
   logic [7:0] rdata;
   logic act;
   logic [31:0] seed = 32'h7422_2a70;
   int bad_count = 0;
   int compares = 0;
   // behavioural model state
   logic [4:0] m_ch = 5'h1f;
   logic [1:0] m_mode = 2'h0;
   logic [1:0] m_hi = 2'h0;
   logic [7:0] m_lo = 8'h00;
   logic [9:0] m_cv = 10'h000;
   logic m_act = 1'b0;
   logic m_trig = 1'b0;
   logic m_cmpen = 1'b0;
   logic m_ge = 1'b0;
   logic m_conversion_complete_flag = 1'b0;
   logic m_lock = 1'b0;
   always #5 clk = ~clk;
   arc_ctrl #(.RES_W(10)) DUT (.i_clock(clk), .i_srst(srst), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_hw_trigger_input(trg),
      .o_conv_start(), .o_conv_abort(), .o_channel_select(), .o_mode(), .i_conv_done(done),
      .i_conv_result(res), .o_conversion_active_flag(act), .o_conversion_complete_flag());
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h0020_0003 : 32'h0000_0000);
   endfunction
   // expected register contents from the model
   function automatic logic [7:0] expv(input logic [2:0] a);
      case (a)
         ARC_OFF_SC1: return {m_conversion_complete_flag, 2'b00, m_ch};
         ARC_OFF_SC2: return {m_act, m_trig, m_cmpen, m_ge, 4'h0};
         ARC_OFF_RES_HI: return {6'h00, m_hi};
         ARC_OFF_RES_LO: return m_lo;
         ARC_OFF_CV_HI: return {6'h00, m_cv[9:8]};
         ARC_OFF_CV_LO: return m_cv[7:0];
         ARC_OFF_CFG: return {4'h0, m_mode, 2'b00};
         default: return 8'h00;
      endcase
   endfunction
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // one-cycle write strobe, model follows
   task automatic wreg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
      if (a == ARC_OFF_SC1) begin
         m_ch = d[4:0];
         m_conversion_complete_flag = 1'b0;
         m_act = !m_trig && d[4:0] != 5'h1f;
      end
      if (a == ARC_OFF_SC2) {m_trig, m_cmpen, m_ge} = d[6:4];
      if (a == ARC_OFF_CV_HI) m_cv[9:8] = d[1:0];
      if (a == ARC_OFF_CV_LO) m_cv[7:0] = d;
      if (a == ARC_OFF_CFG && d[3:2] != m_mode) begin
         {m_hi, m_lo, m_lock} = 11'h000;
         m_mode = d[3:2];
      end
   endtask
   // read, then compare the data that stand in the next cycle
   task automatic rreg(input logic [2:0] a);
      logic [7:0] e;
      e = expv(a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      compares++;
      if (rdata !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, rdata, e);
      end
      if (a == ARC_OFF_RES_HI && m_mode == ARC_MODE_10BIT) m_lock = 1'b1;
      if (a == ARC_OFF_RES_LO) {m_lock, m_conversion_complete_flag} = 2'b00;
   endtask
   // active flag port, looked at one step past the edge that launches it
   task automatic chk_act(input logic e);
      #1;
      compares++;
      if (act !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, act, e);
      end
   endtask
   // core completion pulse carrying a result
   task automatic cdone(input logic [9:0] r);
      int rv;
      int cv;
      @(posedge clk);
      done <= 1'b1;
      res <= r;
      @(posedge clk);
      done <= 1'b0;
      rv = (m_mode == ARC_MODE_10BIT) ? int'(r) : int'(r[7:0]);
      cv = (m_mode == ARC_MODE_10BIT) ? int'(m_cv) : int'(m_cv[7:0]);
      if (m_act && (!m_cmpen || (m_ge ? rv >= cv : rv < cv))) begin
         m_conversion_complete_flag = 1'b1;
         if (!m_lock) begin
            m_lo = r[7:0];
            m_hi = (m_mode == ARC_MODE_10BIT) ? r[9:8] : 2'b00;
         end
      end
      m_act = 1'b0;
   endtask
   // watchdog sized well past the expected run
   initial begin
      repeat (8000) @(posedge clk);
      bad_count++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 8; a++) rreg(3'(a));
      wreg(ARC_OFF_RES_LO, 8'hff);
      wreg(3'h7, 8'hff);
      rreg(ARC_OFF_RES_LO);
      rreg(3'h7);
      $display("test reset values done");
      // random rounds: mode, compare setup, lock and discard
      for (int i = 0; i < 20; i++) begin
         seed = lfsr(seed);
         wreg(ARC_OFF_CFG, {4'h0, seed[0], 3'b000});
         wreg(ARC_OFF_SC2, {2'b00, seed[2:1], 4'h0});
         wreg(ARC_OFF_CV_HI, seed[15:8]);
         wreg(ARC_OFF_CV_LO, seed[23:16]);
         wreg(ARC_OFF_SC1, {4'h0, seed[27:24]});
         rreg(ARC_OFF_SC2);
         cdone(seed[31:22]);
         rreg(ARC_OFF_SC1);
         rreg(ARC_OFF_RES_HI);
         wreg(ARC_OFF_SC1, {4'h0, seed[27:24]});
         cdone(seed[19:10]);
         rreg(ARC_OFF_SC1);
         rreg(ARC_OFF_RES_LO);
         rreg(ARC_OFF_RES_HI);
         rreg(ARC_OFF_CV_HI);
      end
      $display("test random rounds done");
      // compare boundary: equal value with ge set, value one below with ge clear
      wreg(ARC_OFF_CFG, 8'h08);
      // a lock left by the last round would hide the first boundary result
      rreg(ARC_OFF_RES_LO);
      wreg(ARC_OFF_CV_HI, 8'h01);
      wreg(ARC_OFF_CV_LO, 8'h55);
      for (int g = 0; g < 2; g++) begin
         wreg(ARC_OFF_SC2, {3'b001, 1'(1 - g), 4'h0});
         wreg(ARC_OFF_SC1, 8'h02);
         cdone(10'h155 - 10'(g));
         rreg(ARC_OFF_RES_LO);
      end
      $display("test compare boundary done");
      // abort and restart, disabled channel, done while idle
      wreg(ARC_OFF_SC2, 8'h00);
      wreg(ARC_OFF_SC1, 8'h05);
      wreg(ARC_OFF_SC1, 8'h06);
      rreg(ARC_OFF_SC2);
      wreg(ARC_OFF_SC1, 8'h1f);
      rreg(ARC_OFF_SC2);
      cdone(10'h2aa);
      rreg(ARC_OFF_RES_LO);
      $display("test abort done");
      // hardware trigger: control write alone must not start
      wreg(ARC_OFF_SC2, 8'h40);
      wreg(ARC_OFF_SC1, 8'h03);
      rreg(ARC_OFF_SC2);
      @(posedge clk);
      trg <= 1'b1;
      // two synchroniser flops, then the start edge: active shows after the third
      repeat (2) @(posedge clk);
      chk_act(1'b0);
      @(posedge clk);
      chk_act(1'b1);
      m_act = 1'b1;
      rreg(ARC_OFF_SC2);
      cdone(10'h0f0);
      trg <= 1'b0;
      rreg(ARC_OFF_RES_LO);
      $display("test hardware trigger done");
      summarize();
   end
endmodule
`default_nettype wire
